// [src/lvio_pkg.sv]
// Constants shared by the low-voltage port block: register map, fields, reset values.
// Assumes a 32-bit classic Wishbone slave port; registers sit in the low byte of each word.
package lvio_pkg;
  // ------------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // ------------------------------------------------------------------
  localparam logic [7:0] IDX_PORT_CONFIG  = 8'h00;  // port_config_reg, write only
  localparam logic [7:0] IDX_SECOND_DIR   = 8'hF6;  // second_port_direction, write only
  localparam logic [7:0] IDX_THIRD_MODE   = 8'hF7;  // third_port_mode, write only
  localparam logic [7:0] IDX_FIRST_MODE   = 8'hF8;  // first-port nibble direction
  localparam logic [7:0] IDX_FIRST_OUT    = 8'h10;
  localparam logic [7:0] IDX_SECOND_OUT   = 8'h11;
  localparam logic [7:0] IDX_THIRD_OUT    = 8'h12;
  localparam logic [7:0] IDX_FIRST_IN     = 8'h13;
  localparam logic [7:0] IDX_SECOND_IN    = 8'h14;
  localparam logic [7:0] IDX_THIRD_IN     = 8'h15;
  localparam logic [7:0] IDX_IRQ_STAT     = 8'h16;
  localparam logic [7:0] IDX_IRQ_MASK     = 8'h17;
  localparam logic [7:0] IDX_IRQ_EDGE     = 8'h18;
  localparam logic [7:0] IDX_TIMER_ROUTE  = 8'h19;
  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int PORT_CONFIG_CMP_OUT   = 0;  // comparator outputs onto lines four and seven
  localparam int PORT_CONFIG_P0_PP     = 2;  // first port push-pull when set
  localparam int FPM_LO_OUT     = 0;  // lower nibble output when set
  localparam int FPM_HI_OUT     = 1;  // upper nibble output when set
  localparam int P3M_P2_PP      = 0;  // second port push-pull when set
  localparam int P3M_ANALOG     = 1;  // comparator front end enabled
  localparam int EDGE_LO        = 6;  // edge select field, bits 7:6
  localparam int EDGE_HI        = 7;
  localparam int TR_T8_OUT      = 0;  // eight_bit_timer_ctrl bit 0
  localparam int TR_T16_OUT     = 1;  // sixteen_bit_timer_ctrl bit 0
  localparam int TR_COMMON_LO   = 4;  // common_timer_ctrl bits 5:4
  localparam int TR_COMMON_HI   = 5;
  localparam int TR_DEMOD       = 6;  // timer edge input from second_port_line_zero
  localparam int IRQ_ZERO       = 0;
  localparam int IRQ_ONE        = 1;
  localparam int IRQ_TWO        = 2;
  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_PORT_CONFIG = 8'h00;
  localparam logic [7:0] RST_SECOND_DIR  = 8'hFF;  // one = input
  localparam logic [7:0] RST_THIRD_MODE  = 8'h00;
  localparam logic [7:0] RST_FIRST_MODE  = 8'h00;
  localparam logic [7:0] RST_ZERO        = 8'h00;
endpackage

// [src/lvio_edge_if.sv]
// Carrier between the port top and its edge detectors.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface lvio_edge_if;
  logic level;
  logic rise_en;
  logic fall_en;
  logic pulse;
  modport det (input level, input rise_en, input fall_en, output pulse);
  modport ctl (output level, output rise_en, output fall_en, input pulse);
endinterface

// [src/lvio_edge.sv]
// Edge detector for one interrupt line of the fixed port.
// Assumes level is already synchronised to clk_i.
`timescale 1ns/100ps
module lvio_edge (
  input  wire logic clk_i,
  input  wire logic rst_i,
  lvio_edge_if.det  e
);
  logic prev_r;
  logic primed_r;
  logic pulse_r;

  // Prime after reset so a line held high gives no false edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_r   <= 1'b0;
      primed_r <= 1'b0;
    end else begin
      prev_r   <= e.level;
      primed_r <= 1'b1;
    end
  end

  // One-cycle pulse on a selected edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_r <= 1'b0;
    end else begin
      pulse_r <= primed_r & ((e.rise_en & e.level & ~prev_r) | (e.fall_en & ~e.level & prev_r));
    end
  end

  assign e.pulse = pulse_r;
endmodule // lvio_edge

// [src/lvio_top.sv]
// Port logic of a low-voltage microcontroller: nibble port, bit port with wake gates, fixed port.
// Assumes a classic Wishbone master on clk_i, pins and comparator results asynchronous.
//
// Operation
// R1 - First port direction set per nibble
// R2 - First port push-pull or open-drain select
// R3 - First port all inputs after reset
// R4 - Pull-ups off on lines driven out
// R5 - Second port direction per line, always usable
// R6 - Second port one global drive type
// R7 - Second port all inputs after reset
// R8 - Second port AND and OR wake gates
// R9 - Line zero feeds timer edge in demodulation
// R10 - Fixed port: three inputs, four outputs
// R11 - Analog mode enables comparators on lines one, two
// R12 - Lines one, two interrupt edge selectable
// R13 - Timer edge input from line one or zero
// R14 - Timer control bits route fixed outputs
// R15 - Line three: input bit or stop source
// R16 - Comparators powered down in stop mode
// R17 - Comparator outputs onto lines four, seven
// R18 - Unassigned fixed outputs drive data latch
//
// The Wishbone register port was decided locally.
`timescale 1ns/100ps
module lvio_top
  import lvio_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  p0_i,
  output logic      [7:0]  p0_o,
  output logic      [7:0]  p0_oe_n_o,
  output logic      [7:0]  p0_pu_o,
  input  wire logic [7:0]  p2_i,
  output logic      [7:0]  p2_o,
  output logic      [7:0]  p2_oe_n_o,
  output logic      [7:0]  p2_pu_o,
  input  wire logic [2:0]  p3_i,
  output logic      [3:0]  p3_o,
  input  wire logic        cmp_a_i,
  input  wire logic        cmp_b_i,
  output logic             cmp_pwr_o,
  input  wire logic        stop_i,
  input  wire logic        t8_out_i,
  input  wire logic        t16_out_i,
  input  wire logic        t816_out_i,
  output logic             tmr_edge_o,
  output logic             wake_or_o,
  output logic             wake_and_o,
  output logic             stop_src_o,
  output logic             irq_o
);
  import lvio_pkg::*;

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  logic [7:0] port_config_r, p2m_r, p3m_r, fpm_r;
  logic [7:0] p0_out_r, p2_out_r, p3_out_r;
  logic [2:0] irq_stat_r, irq_mask_r;
  logic [7:0] irq_edge_r, troute_r;
  logic [7:0] p0_s1, p0_s2, p2_s1, p2_s2;
  logic [2:0] p3_s1, p3_s2;
  logic [1:0] cmp_s1, cmp_s2;
  logic       ack_r;
  logic [31:0] dat_r;
  logic [3:0] p3_drv_r;
  logic [7:0] p0_dir;
  logic       analog;
  logic [2:0] sense;
  logic [2:0] irq_set;
  logic       wr_fire;
  logic [7:0] wr_byte;
  logic [7:0] idx;

  // Register index decode shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  // Two flops on every pin; first stage read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p0_s1  <= 8'h00;
      p0_s2  <= 8'h00;
      p2_s1  <= 8'h00;
      p2_s2  <= 8'h00;
      p3_s1  <= 3'h0;
      p3_s2  <= 3'h0;
      cmp_s1 <= 2'h0;
      cmp_s2 <= 2'h0;
    end else begin
      p0_s1  <= p0_i;
      p0_s2  <= p0_s1;
      p2_s1  <= p2_i;
      p2_s2  <= p2_s1;
      p3_s1  <= p3_i;
      p3_s2  <= p3_s1;
      cmp_s1 <= {cmp_b_i, cmp_a_i};
      cmp_s2 <= cmp_s1;
    end
  end

  // ------------------------------------------------------------------
  // Wishbone slave
  // ------------------------------------------------------------------
  // Ack one cycle after strobe; write lands on the ack edge
  assign idx     = wb_adr_i[9:2];
  assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & ack_r & wb_sel_i[0];
  assign wr_byte = wb_dat_i[7:0];
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
    end
  end

  // Read data captured at request; write-only and unmapped read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (wb_cyc_i & wb_stb_i & ~ack_r) begin
      dat_r <= 32'h0000_0000;
      if (hit(idx, IDX_FIRST_OUT))   dat_r[7:0] <= p0_out_r;
      if (hit(idx, IDX_SECOND_OUT))  dat_r[7:0] <= p2_out_r;
      if (hit(idx, IDX_THIRD_OUT))   dat_r[7:0] <= p3_out_r;
      if (hit(idx, IDX_FIRST_IN))    dat_r[7:0] <= p0_s2;
      if (hit(idx, IDX_SECOND_IN))   dat_r[7:0] <= p2_s2;
      if (hit(idx, IDX_THIRD_IN))    dat_r[7:0] <= {4'h0, sense, 1'b0};
      if (hit(idx, IDX_IRQ_STAT))    dat_r[7:0] <= {5'h00, irq_stat_r};
      if (hit(idx, IDX_IRQ_MASK))    dat_r[7:0] <= {5'h00, irq_mask_r};
      if (hit(idx, IDX_IRQ_EDGE))    dat_r[7:0] <= irq_edge_r;
      if (hit(idx, IDX_TIMER_ROUTE)) dat_r[7:0] <= troute_r;
    end
  end

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------
  // Mode registers; reset leaves every first and second port line an input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_config_r <= RST_PORT_CONFIG;
      p2m_r  <= RST_SECOND_DIR;  // R7
      p3m_r  <= RST_THIRD_MODE;
      fpm_r  <= RST_FIRST_MODE;  // R3
    end else if (wr_fire) begin
      if (hit(idx, IDX_PORT_CONFIG)) port_config_r <= wr_byte;
      if (hit(idx, IDX_SECOND_DIR))  p2m_r  <= wr_byte;  // R5
      if (hit(idx, IDX_THIRD_MODE))  p3m_r  <= wr_byte;
      if (hit(idx, IDX_FIRST_MODE))  fpm_r  <= wr_byte;  // R1
    end
  end

  // Output data latches and routing controls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p0_out_r   <= RST_ZERO;
      p2_out_r   <= RST_ZERO;
      p3_out_r   <= RST_ZERO;
      irq_mask_r <= 3'h0;
      irq_edge_r <= RST_ZERO;
      troute_r   <= RST_ZERO;
    end else if (wr_fire) begin
      if (hit(idx, IDX_FIRST_OUT))   p0_out_r   <= wr_byte;
      if (hit(idx, IDX_SECOND_OUT))  p2_out_r   <= wr_byte;
      if (hit(idx, IDX_THIRD_OUT))   p3_out_r   <= wr_byte;
      if (hit(idx, IDX_IRQ_MASK))    irq_mask_r <= wr_byte[2:0];
      if (hit(idx, IDX_IRQ_EDGE))    irq_edge_r <= wr_byte;
      if (hit(idx, IDX_TIMER_ROUTE)) troute_r   <= wr_byte;
    end
  end

  // ------------------------------------------------------------------
  // First and second port drivers
  // ------------------------------------------------------------------
  // Open drain only pulls low; enable is active low
  assign p0_dir    = {{4{fpm_r[FPM_HI_OUT]}}, {4{fpm_r[FPM_LO_OUT]}}};  // R1
  assign p0_o      = p0_out_r;
  assign p0_oe_n_o = ~(p0_dir & ({8{port_config_r[PORT_CONFIG_P0_PP]}} | ~p0_out_r));  // R2
  assign p0_pu_o   = ~p0_dir;  // R4
  assign p2_o      = p2_out_r;
  assign p2_oe_n_o = ~(~p2m_r & ({8{p3m_r[P3M_P2_PP]}} | ~p2_out_r));  // R6
  assign p2_pu_o   = p2m_r;  // R4

  // Wake gates look at the pins whatever their direction
  assign wake_or_o  = |p2_s2;  // R8
  assign wake_and_o = &p2_s2;  // R8

  // ------------------------------------------------------------------
  // Fixed port inputs and comparators
  // ------------------------------------------------------------------
  // Comparators sleep in stop mode to save supply current
  assign analog    = p3m_r[P3M_ANALOG];  // R11
  assign cmp_pwr_o = analog & ~stop_i;  // R16
  assign sense     = analog ? {p3_s2[2], cmp_s2} : p3_s2;  // R10 R11
  assign stop_src_o = analog & p3_s2[2];  // R15
  assign tmr_edge_o = troute_r[TR_DEMOD] ? p2_s2[0] : sense[0];  // R9 R13

  lvio_edge_if e1 ();
  lvio_edge_if e2 ();
  lvio_edge_if e3 ();

  // Edge field 00 falls, 01 line two rises, 10 line one rises, 11 both
  assign e1.level   = sense[0];
  assign e1.rise_en = irq_edge_r[EDGE_HI];  // R12
  assign e1.fall_en = ~irq_edge_r[EDGE_HI] | irq_edge_r[EDGE_LO];  // R12
  assign e2.level   = sense[1];
  assign e2.rise_en = irq_edge_r[EDGE_LO];  // R12
  assign e2.fall_en = ~irq_edge_r[EDGE_LO] | irq_edge_r[EDGE_HI];  // R12
  assign e3.level   = p3_s2[2];
  assign e3.rise_en = 1'b0;
  assign e3.fall_en = 1'b1;

  lvio_edge u_edge1 (.clk_i(clk_i), .rst_i(rst_i), .e(e1));
  lvio_edge u_edge2 (.clk_i(clk_i), .rst_i(rst_i), .e(e2));
  lvio_edge u_edge3 (.clk_i(clk_i), .rst_i(rst_i), .e(e3));

  // Line three raises interrupt one only in digital mode
  assign irq_set[IRQ_ZERO] = e2.pulse;
  assign irq_set[IRQ_ONE]  = e3.pulse & ~analog;  // R15
  assign irq_set[IRQ_TWO]  = e1.pulse;

  // ------------------------------------------------------------------
  // Interrupt status
  // ------------------------------------------------------------------
  // Write one clears; a new event in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= 3'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr_fire & hit(idx, IDX_IRQ_STAT)) ? wr_byte[2:0] : 3'h0)) | irq_set;
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

  // ------------------------------------------------------------------
  // Fixed port outputs
  // ------------------------------------------------------------------
  // Registered mux so pins never glitch between sources
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p3_drv_r <= 4'h0;
    end else begin
      p3_drv_r[0] <= port_config_r[PORT_CONFIG_CMP_OUT] ? cmp_s2[0] :  // R17
                     troute_r[TR_T8_OUT] ? t8_out_i : p3_out_r[4];  // R14 R18
      p3_drv_r[1] <= troute_r[TR_T16_OUT] ? t16_out_i : p3_out_r[5];  // R14 R18
      case (troute_r[TR_COMMON_HI:TR_COMMON_LO])  // R14
        2'h1:    p3_drv_r[2] <= t8_out_i;
        2'h2:    p3_drv_r[2] <= t16_out_i;
        2'h3:    p3_drv_r[2] <= t816_out_i;
        default: p3_drv_r[2] <= p3_out_r[6];  // R18
      endcase
      p3_drv_r[3] <= port_config_r[PORT_CONFIG_CMP_OUT] ? cmp_s2[1] : p3_out_r[7];  // R17 R18
    end
  end

  assign p3_o = p3_drv_r;  // R10

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  property p_p0_nibble;
    @(posedge clk_i) disable iff (rst_i)
    !fpm_r[FPM_LO_OUT] |-> (p0_oe_n_o[3:0] == 4'hF);
  endproperty
  a_p0_nibble: assert property (p_p0_nibble) else $error("lower nibble driven while input"); // R1

  property p_p0_od;
    @(posedge clk_i) disable iff (rst_i)
    (!port_config_r[PORT_CONFIG_P0_PP] && p0_out_r[0]) |-> p0_oe_n_o[0];
  endproperty
  a_p0_od: assert property (p_p0_od) else $error("open drain drove a high"); // R2

  property p_p0_reset;
    @(posedge clk_i) rst_i |=> (p0_oe_n_o == 8'hFF) && (p2_oe_n_o == 8'hFF);
  endproperty
  a_p0_reset: assert property (p_p0_reset) else $error("port driven after reset"); // R3

  property p_pullup_off;
    @(posedge clk_i) disable iff (rst_i)
    ((p0_pu_o & ~p0_oe_n_o) == 8'h00) && ((p2_pu_o & ~p2_oe_n_o) == 8'h00);
  endproperty
  a_pullup_off: assert property (p_pullup_off) else $error("pull-up on a driven line"); // R4

  property p_p2_global;
    @(posedge clk_i) disable iff (rst_i)
    !p3m_r[P3M_P2_PP] |-> ((~p2_oe_n_o & p2_out_r) == 8'h00);
  endproperty
  a_p2_global: assert property (p_p2_global) else $error("second port open drain drove a high"); // R6

  property p_wake_or;
    @(posedge clk_i) disable iff (rst_i)
    (p2_i == 8'h00) [*3] |-> !wake_or_o;
  endproperty
  a_wake_or: assert property (p_wake_or) else $error("or gate high with all lines low"); // R8

  property p_cmp_stop;
    @(posedge clk_i) disable iff (rst_i)
    stop_i |-> !cmp_pwr_o;
  endproperty
  a_cmp_stop: assert property (p_cmp_stop) else $error("comparators powered in stop"); // R16

  property p_irq_set;
    @(posedge clk_i) disable iff (rst_i)
    e1.pulse |=> irq_stat_r[IRQ_TWO];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("line one edge lost"); // R12

  property p_line3_analog;
    @(posedge clk_i) disable iff (rst_i)
    (analog && $stable(analog)) |-> !irq_set[IRQ_ONE];
  endproperty
  a_line3_analog: assert property (p_line3_analog) else $error("interrupt one in analog mode"); // R15

  property p_cmp_route;
    @(posedge clk_i) disable iff (rst_i)
    (port_config_r[PORT_CONFIG_CMP_OUT] && !$past(rst_i)) |=> (p3_o[3] == $past(cmp_s2[1]));
  endproperty
  a_cmp_route: assert property (p_cmp_route) else $error("line seven not comparator"); // R17

  property p_latch_out;
    @(posedge clk_i) disable iff (rst_i)
    !troute_r[TR_T16_OUT] |=> (p3_o[1] == $past(p3_out_r[5]));
  endproperty
  a_latch_out: assert property (p_latch_out) else $error("line five not from latch"); // R18

  c_irq:    cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
  c_analog: cover property (@(posedge clk_i) disable iff (rst_i) analog && stop_src_o);
  c_drive:  cover property (@(posedge clk_i) disable iff (rst_i) p0_oe_n_o == 8'h00);
endmodule // lvio_top

// [tb/lvio_pin_model.sv]
// Far-side model of one bidirectional port: device drive, board drive, pull-up, floating line.
// Assumes the bench supplies the board's drive and its per-line enable.
`timescale 1ns/100ps
module lvio_pin_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_n_i,
  input  wire logic [7:0] pu_i,
  input  wire logic [7:0] ext_i,
  input  wire logic [7:0] ext_en_i,
  output logic      [7:0] lvl_o
);
  logic [7:0] float_r = 8'h5A;
  // ----------------------------------------------------------------
  // Floating lines
  // ----------------------------------------------------------------
  // Pattern changes every cycle so a stale level is never trusted
  always_ff @(posedge clk_i) begin
    float_r <= ~float_r;
  end
  // Device drive wins, then the board, then the pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!oe_n_i[i]) lvl_o[i] = drv_i[i];
      else if (ext_en_i[i]) lvl_o[i] = ext_i[i];
      else if (pu_i[i]) lvl_o[i] = 1'b1;
      else lvl_o[i] = float_r[i];
    end
  end
endmodule // lvio_pin_model

// [tb/testbench.sv]
// Self-checking bench of the port block: registers over Wishbone, pins through the pin model.
// Assumes the design package and the pin model are compiled first.
`timescale 1ns/100ps
module testbench;
  import lvio_pkg::*;
  logic        clk_i, rst_i, cyc, stb, we, ack, a, b, pwr, stop, t8, t16, tedge, wk_or, wk_and, ssrc, irq;
  logic [9:0]  adr;
  logic [3:0]  sel, p3_o;
  logic [31:0] wdat, rdat, seed;
  logic [7:0]  p0_i, p0_o, p0_oe, p0_pu, p2_i, p2_o, p2_oe, p2_pu, ext0, ext2, q, v, l, d, r;
  logic [2:0]  p3_i;
  int          miscompares, comparisons, m, k;

  lvio_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .p0_i(p0_i), .p0_o(p0_o), .p0_oe_n_o(p0_oe), .p0_pu_o(p0_pu), .p2_i(p2_i), .p2_o(p2_o),
    .p2_oe_n_o(p2_oe), .p2_pu_o(p2_pu), .p3_i(p3_i), .p3_o(p3_o), .cmp_a_i(a), .cmp_b_i(b),
    .cmp_pwr_o(pwr), .stop_i(stop), .t8_out_i(t8), .t16_out_i(t16), .t816_out_i(t8),
    .tmr_edge_o(tedge), .wake_or_o(wk_or), .wake_and_o(wk_and), .stop_src_o(ssrc), .irq_o(irq));
  lvio_pin_model pm0 (.clk_i(clk_i), .drv_i(p0_o), .oe_n_i(p0_oe), .pu_i(p0_pu), .ext_i(ext0),
    .ext_en_i(8'hFF), .lvl_o(p0_i));
  lvio_pin_model pm2 (.clk_i(clk_i), .drv_i(p2_o), .oe_n_i(p2_oe), .pu_i(p2_pu), .ext_i(ext2),
    .ext_en_i(8'hFF), .lvl_o(p2_i));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  // Open-drain releases lines whose latch holds one
  function automatic logic [7:0] exp_oe(input logic pp, input logic [7:0] o, input logic [7:0] lt);
    return ~o | (pp ? 8'h00 : lt);
  endfunction
  function automatic logic exp_edge(input int md, input int sel_md, input logic rise);
    return md == 3 || (rise ? md == sel_md : md != sel_md);
  endfunction
  function automatic logic [3:0] exp_p3(input logic [7:0] rt, input logic [7:0] lt);
    return {lt[7], rt[5:4] == 2'b01 ? t8 : rt[5:4] == 2'b10 ? t16 : lt[6],
            rt[1] ? t16 : lt[5], rt[0] ? t8 : lt[4]};
  endfunction
  // Byte wide so an inverted expectation is not widened with ones
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One classic cycle; holds until ack is sampled, then idles two cycles
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] dt);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    wdat <= {24'h000000, dt};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    if (n >= 20) begin
      miscompares++;
      finish_test();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_i, cyc, stb, we, adr, sel, wdat, a, b, stop, t8, t16} = {1'b1, 13'h0, 4'h1, 37'h0};
    {miscompares, comparisons, seed, ext0, ext2, p3_i} = {64'h0, 32'h0001248C, 19'h7FFFF};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("p0_oe", 8'hFF, p0_oe);
    chk("p2_oe", 8'hFF, p2_oe);
    chk("p2_pu", 8'hFF, p2_pu);
    wb(1, 8'h40, 8'h5A);
    wb(0, 8'h40, 0);
    chk("unmapped", 8'h00, q);
    $display("test reset done");
    // Nibble direction, then drive type with a random latch
    for (m = 0; m < 4; m++) begin
      wb(1, IDX_FIRST_MODE, m[7:0]);
      chk("p0_oe", ~{{4{m[1]}}, {4{m[0]}}}, p0_oe);
      chk("p0_pu", ~{{4{m[1]}}, {4{m[0]}}}, p0_pu);
    end
    v = rnd();
    wb(1, IDX_FIRST_OUT, v);
    chk("p0_oe od", exp_oe(0, 8'hFF, v), p0_oe);
    wb(1, IDX_PORT_CONFIG, 8'h04);
    chk("p0_oe pp", exp_oe(1, 8'hFF, v), p0_oe);
    repeat (3) @(posedge clk_i);
    wb(0, IDX_FIRST_IN, 0);
    chk("p0 loop", v, q);
    $display("test first port done");
    // Random per-line direction on the second port
    wb(1, IDX_THIRD_MODE, 8'h01);
    for (m = 0; m < 4; m++) begin
      d = rnd();
      l = rnd();
      ext2 <= rnd();
      wb(1, IDX_SECOND_DIR, d);
      wb(1, IDX_SECOND_OUT, l);
      chk("p2_oe", exp_oe(1, ~d, l), p2_oe);
      chk("p2_pu", d, p2_pu);
      repeat (3) @(posedge clk_i);
      wb(0, IDX_SECOND_IN, 0);
      chk("p2 in", (d & ext2) | (~d & l), q);
    end
    wb(1, IDX_THIRD_MODE, 8'h00);
    chk("p2_oe od", exp_oe(0, ~d, l), p2_oe);
    wb(1, IDX_SECOND_DIR, 8'hFF);
    for (m = 0; m < 4; m++) begin
      v = (m == 0) ? 8'h00 : (m == 1) ? 8'hFF : (m == 2) ? 8'hFE : rnd();
      ext2 <= v;
      repeat (5) @(posedge clk_i);
      chk("wake_or", |v, wk_or);
      chk("wake_and", &v, wk_and);
    end
    // Timer edge source, normal and demodulation
    for (m = 0; m < 8; m++) begin
      if (m[1:0] == 0) wb(1, IDX_TIMER_ROUTE, {1'b0, m[2], 6'h00});
      ext2[0] <= m[0];
      p3_i[0] <= m[1];
      repeat (5) @(posedge clk_i);
      chk("tmr_edge", m[2] ? m[0] : m[1], tedge);
    end
    $display("test second port done");
    // Fixed outputs: latch versus timer routing
    for (m = 0; m < 8; m++) begin
      r = rnd() & 8'h33;
      if (r[5:4] == 2'b11) r[4] = 1'b0;
      l = rnd();
      t8 <= l[0];
      t16 <= l[3];
      wb(1, IDX_THIRD_OUT, l);
      wb(1, IDX_TIMER_ROUTE, r);
      chk("p3_o", exp_p3(r, l), p3_o);
    end
    // Comparators in analog mode
    wb(1, IDX_THIRD_MODE, 8'h02);
    wb(1, IDX_PORT_CONFIG, 8'h05);
    chk("cmp_pwr", 1'b1, pwr);
    for (m = 0; m < 4; m++) begin
      a <= m[0];
      b <= m[1];
      repeat (5) @(posedge clk_i);
      chk("p3_o cmp", {m[1], 2'b00, m[0]}, p3_o & 4'h9);
      wb(0, IDX_THIRD_IN, 0);
      chk("cmp in", m[1:0], q[2:1]);
    end
    stop <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("cmp_pwr stop", 1'b0, pwr);
    chk("stop_src on", 1'b1, ssrc);
    stop <= 1'b0;
    wb(1, IDX_IRQ_STAT, 8'h07);
    p3_i <= 3'b011;
    repeat (6) @(posedge clk_i);
    wb(0, IDX_IRQ_STAT, 0);
    chk("line3 analog", 1'b0, q[1]);
    chk("stop_src off", 1'b0, ssrc);
    wb(1, IDX_THIRD_MODE, 8'h00);
    p3_i <= 3'b111;
    repeat (6) @(posedge clk_i);
    wb(1, IDX_IRQ_STAT, 8'h07);
    p3_i <= 3'b011;
    repeat (6) @(posedge clk_i);
    wb(0, IDX_IRQ_STAT, 0);
    chk("line3 digital", 3'b010, q[2:0]);
    wb(0, IDX_THIRD_IN, 0);
    chk("line3 in", 1'b0, q[3]);
    $display("test fixed port done");
    // Every edge mode, both directions, both lines at once
    for (m = 0; m < 8; m++) begin
      if (!m[0]) wb(1, IDX_IRQ_EDGE, {m[2:1], 6'h00});
      wb(1, IDX_IRQ_STAT, 8'h07);
      p3_i[1:0] <= {2{m[0]}};
      repeat (6) @(posedge clk_i);
      wb(0, IDX_IRQ_STAT, 0);
      chk("edge stat", {exp_edge(m / 2, 2, m[0]), 1'b0, exp_edge(m / 2, 1, m[0])}, q[2:0]);
    end
    // Mask, level output and write-one clear
    wb(1, IDX_IRQ_MASK, 8'h04);
    wb(1, IDX_IRQ_STAT, 8'h07);
    chk("irq idle", 1'b0, irq);
    p3_i[0] <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("irq on", 1'b1, irq);
    wb(1, IDX_IRQ_MASK, 8'h00);
    chk("irq masked", 1'b0, irq);
    wb(1, IDX_IRQ_MASK, 8'h04);
    chk("irq unmasked", 1'b1, irq);
    wb(1, IDX_IRQ_STAT, 8'h04);
    chk("irq cleared", 1'b0, irq);
    $display("test interrupts done");
    finish_test();
  end
endmodule // testbench
